//--- verilog/glpc_top.sv
// Implementation choices: register access over APB and the address map.
`timescale 1ns/10ps
module glpc_top (
    input  wire logic                         clk,
    input  wire logic                         resetn,
    input  wire logic                         tx_gate_pin,
    input  wire logic                         serial_out_edge_sel,
    input  wire logic                         host_port_select,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [glpc_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    output logic      [glpc_pkg::NUM_CH-1:0]  tx_line_pos_oe,
    output logic      [glpc_pkg::NUM_CH-1:0]  tx_line_neg_oe,
    output logic      [glpc_pkg::NUM_CH-1:0]  rx_term_en,
    output logic      [glpc_pkg::NUM_CH-1:0]  rx_monitor_en,
    output logic                              sdo_launch_fall,
    output logic                              bus_mux_mode
);
    import glpc_pkg::*;

    // ****************************************
    // Reset release synchroniser
    // ****************************************
    logic [1:0] rst_sync_reg;
    logic [1:0] rst_sync_next;
    logic       rst_n_int;

    always_comb begin
        rst_sync_next = {rst_sync_reg[0], 1'b1};
    end

    // Assert at once, release two edges later
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= rst_sync_next;
        end
    end

    assign rst_n_int = rst_sync_reg[1];

    // ****************************************
    // Pin synchronisers
    // ****************************************
    glpc_pins_t pins_s;

    glpc_sync #(
        .WIDTH (3)
    ) u_pin_sync (
        .clk      (clk),
        .rst_n    (rst_n_int),
        .async_in ({tx_gate_pin, serial_out_edge_sel, host_port_select}),
        .sync_out (pins_s)
    );

    // ****************************************
    // APB register file
    // ****************************************
    logic [NUM_CH-1:0] oe_ctrl_reg;
    logic [NUM_CH-1:0] oe_ctrl_next;
    logic              term_ctrl_reg;
    logic              term_ctrl_next;
    logic [31:0]       prdata_reg;
    logic [31:0]       prdata_next;
    logic [31:0]       status_word;
    logic              setup_ph;
    logic              wr_acc;

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        return (a == TX_OE_OFS) || (a == TEST_OFS) || (a == STATUS_OFS);
    endfunction

    assign setup_ph = psel && !penable;
    assign wr_acc   = psel && penable && pwrite;
    assign pready   = psel && penable;
    assign pslverr  = psel && penable && !addr_mapped(paddr);

    always_comb begin
        status_word              = ZERO_WORD;
        status_word[ST_GATE_BIT] = pins_s.tx_gate;
        status_word[ST_EDGE_BIT] = pins_s.edge_sel;
        status_word[ST_PORT_BIT] = pins_s.port_sel;
        status_word[ST_FALL_BIT] = sdo_launch_fall;
        status_word[ST_MUX_BIT]  = bus_mux_mode;
    end

    always_comb begin
        oe_ctrl_next   = oe_ctrl_reg;
        term_ctrl_next = term_ctrl_reg;
        prdata_next    = prdata_reg;
        if (wr_acc && paddr == TX_OE_OFS) begin
            oe_ctrl_next = pwdata[NUM_CH-1:0];
        end
        if (wr_acc && paddr == TEST_OFS) begin
            term_ctrl_next = pwdata[TEST_TERM_BIT];
        end
        // Read data captured in setup, stable through access
        if (setup_ph) begin
            unique case (paddr)
                TX_OE_OFS:  prdata_next = {16'h0000, oe_ctrl_reg};
                TEST_OFS:   prdata_next = {31'h0000_0000, term_ctrl_reg};
                STATUS_OFS: prdata_next = status_word;
                default:    prdata_next = ZERO_WORD;
            endcase
        end
    end

    // Defaults restored whenever reset is held
    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            oe_ctrl_reg   <= TX_OE_RST;
            term_ctrl_reg <= TERM_CTRL_RST;
            prdata_reg    <= ZERO_WORD;
        end else begin
            oe_ctrl_reg   <= oe_ctrl_next;
            term_ctrl_reg <= term_ctrl_next;
            prdata_reg    <= prdata_next;
        end
    end

    assign prdata = prdata_reg;

    // ****************************************
    // Line output, termination and host mode
    // ****************************************
    logic [NUM_CH-1:0] tx_oe_reg;
    logic [NUM_CH-1:0] tx_oe_next;
    logic [NUM_CH-1:0] term_reg;
    logic [NUM_CH-1:0] term_next;
    logic              fall_reg;
    logic              fall_next;
    logic              mux_reg;
    logic              mux_next;

    always_comb begin
        // Gate pin overrides every channel bit
        tx_oe_next = pins_s.tx_gate ? oe_ctrl_reg : '0;
        // Without the test bit the pin has no say on termination
        term_next  = '1;
        if (term_ctrl_reg) begin
            term_next = pins_s.tx_gate ? '1 : '0;
        end
        fall_next = fall_reg;
        mux_next  = mux_reg;
        // Shared pin meaning follows host port choice
        if (!pins_s.port_sel) begin
            fall_next = pins_s.edge_sel;
        end else begin
            mux_next = pins_s.edge_sel;
        end
    end

    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            tx_oe_reg <= '0;
            term_reg  <= '0;
            fall_reg  <= 1'b0;
            mux_reg   <= 1'b0;
        end else begin
            tx_oe_reg <= tx_oe_next;
            term_reg  <= term_next;
            fall_reg  <= fall_next;
            mux_reg   <= mux_next;
        end
    end

    assign tx_line_pos_oe  = tx_oe_reg;
    assign tx_line_neg_oe  = tx_oe_reg;
    assign rx_term_en      = term_reg;
    // Monitoring never depends on termination state
    assign rx_monitor_en   = '1;
    assign sdo_launch_fall = fall_reg;
    assign bus_mux_mode    = mux_reg;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_int);

    sequence s_oe_write;
        psel && penable && pwrite && paddr == TX_OE_OFS;
    endsequence

    a_gate_low_hiz: assert property (!pins_s.tx_gate |=>
        tx_line_pos_oe == '0 && tx_line_neg_oe == '0)
        else $error("line outputs driven while gate low");
    a_gate_high_chan: assert property (pins_s.tx_gate |=>
        tx_line_pos_oe == $past(oe_ctrl_reg))
        else $error("line enable differs from channel bits");
    a_chan_and: assert property (##1 tx_line_neg_oe ==
        ($past(oe_ctrl_reg) & {NUM_CH{$past(pins_s.tx_gate)}}))
        else $error("line enable is not gate AND channel bit");
    a_term_free: assert property (!term_ctrl_reg |=> rx_term_en == '1)
        else $error("termination moved without pin control");
    a_term_gate_low: assert property (term_ctrl_reg && !pins_s.tx_gate |=>
        rx_term_en == '0)
        else $error("termination on while gate low");
    a_term_gate_high: assert property (term_ctrl_reg && pins_s.tx_gate |=>
        rx_term_en == '1)
        else $error("termination off while gate high");
    a_monitor_on: assert property (rx_term_en == '0 |-> rx_monitor_en == '1)
        else $error("monitor lost while unterminated");
    a_edge_select: assert property (!pins_s.port_sel |=>
        sdo_launch_fall == $past(pins_s.edge_sel))
        else $error("serial launch edge wrong");
    a_mux_select: assert property (pins_s.port_sel |=>
        bus_mux_mode == $past(pins_s.edge_sel) && $stable(sdo_launch_fall))
        else $error("bus multiplex mode wrong");
    a_reset_default: assert property ($rose(rst_n_int) |->
        oe_ctrl_reg == TX_OE_RST && term_ctrl_reg == TERM_CTRL_RST)
        else $error("registers not at default after reset");
    a_oe_write: assert property (s_oe_write |=>
        oe_ctrl_reg == $past(pwdata[NUM_CH-1:0]))
        else $error("channel enable write lost");
    a_reset_sync: assert property (@(posedge clk) disable iff (!resetn)
        $rose(rst_sync_reg[0]) |=> rst_n_int)
        else $error("reset release not two edges");

endmodule

//--- verilog/glpc_pkg.sv
package glpc_pkg;

    // ****************************************
    // Sizes and register map
    // ****************************************
    localparam int          NUM_CH        = 16;
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] TX_OE_OFS     = 12'h000;
    localparam logic [11:0] TEST_OFS      = 12'h004;
    localparam logic [11:0] STATUS_OFS    = 12'h008;
    localparam logic [15:0] TX_OE_RST     = 16'h0000;
    localparam logic        TERM_CTRL_RST = 1'b0;
    localparam int          TEST_TERM_BIT = 0;
    localparam int          ST_GATE_BIT   = 0;
    localparam int          ST_EDGE_BIT   = 1;
    localparam int          ST_PORT_BIT   = 2;
    localparam int          ST_FALL_BIT   = 3;
    localparam int          ST_MUX_BIT    = 4;
    localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 5;
    localparam int RESET_MIN_NS  = 1000;
    localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************
    // Static control pins, after synchronising
    // ****************************************
    typedef struct packed {
        logic tx_gate;
        logic edge_sel;
        logic port_sel;
    } glpc_pins_t;

endpackage

//--- verilog/glpc_sync.sv
`timescale 1ns/10ps
module glpc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule

//--- tb/glpc_host_model.sv
`timescale 1ns/10ps
// ****************************************
// Host board: static control pins
// ****************************************
// Pins move only just after a rising edge, like a board controller
module glpc_host_model (
    input  wire logic clk,
    input  wire logic want_gate,
    input  wire logic want_edge,
    input  wire logic want_port,
    output logic      tx_gate_pin,
    output logic      serial_out_edge_sel,
    output logic      host_port_select
);
    initial begin
        tx_gate_pin         = 1'b0;
        serial_out_edge_sel = 1'b0;
        host_port_select    = 1'b0;
    end

    always @(posedge clk) begin
        tx_gate_pin         <= want_gate;
        serial_out_edge_sel <= want_edge;
        host_port_select    <= want_port;
    end
endmodule

//--- tb/global_pin_control_tb_top.sv
`timescale 1ns/10ps
module global_pin_control_tb_top;
    import glpc_pkg::*;
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr, er, t, xf, xm;
    logic        g, e, p, gate_pin, edge_pin, port_pin, sdo_launch_fall, bus_mux_mode;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] oe, tx_line_pos_oe, tx_line_neg_oe, rx_term_en, rx_monitor_en;
    int          n_fail, checked, i;

    always #(CLK_PERIOD_NS / 2.0) clk = ~clk;

    glpc_host_model host (.clk(clk), .want_gate(g), .want_edge(e), .want_port(p),
        .tx_gate_pin(gate_pin), .serial_out_edge_sel(edge_pin), .host_port_select(port_pin));

    glpc_top uut (.clk(clk), .resetn(resetn), .tx_gate_pin(gate_pin),
        .serial_out_edge_sel(edge_pin), .host_port_select(port_pin), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tx_line_pos_oe(tx_line_pos_oe),
        .tx_line_neg_oe(tx_line_neg_oe), .rx_term_en(rx_term_en),
        .rx_monitor_en(rx_monitor_en), .sdo_launch_fall(sdo_launch_fall),
        .bus_mux_mode(bus_mux_mode));

    // ****************************************
    // Tasks and expectations
    // ****************************************
    task automatic finish_test;
        if (n_fail == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // No cycle count assumed; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Pin path: model flop, two sync flops, output flop, plus margin
    task automatic pins(input logic pg, input logic pe, input logic pp);
        @(posedge clk);
        g <= pg;
        e <= pe;
        p <= pp;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask

    function automatic logic [31:0] exp_oe(input logic eg, input logic [15:0] eo);
        return eg ? {16'h0000, eo} : ZERO_WORD;
    endfunction

    function automatic logic [31:0] exp_term(input logic eg, input logic et);
        return et ? {16'h0000, {16{eg}}} : 32'h0000_ffff;
    endfunction

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        clk = 0; resetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
        g = 0; e = 0; p = 0; n_fail = 0; checked = 0; xf = 0; xm = 0;
        void'($urandom(72873));
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (10) @(posedge clk);
        apb(1'b0, TX_OE_OFS, ZERO_WORD);
        chk(rd, 32'(TX_OE_RST));
        apb(1'b0, TEST_OFS, ZERO_WORD);
        chk(rd, 32'(TERM_CTRL_RST));
        apb(1'b0, 12'h00c, ZERO_WORD);
        chk({rd[30:0], er}, 32'h0000_0001);
        for (i = 0; i < 10; i++) begin
            oe = (i < 2) ? 16'hffff : 16'($urandom);
            t  = (i < 4) ? i[1] : 1'($urandom);
            apb(1'b1, TX_OE_OFS, {16'h0000, oe});
            apb(1'b1, TEST_OFS, {31'h0, t});
            pins(i[0], 1'b0, 1'b0);
            chk(32'(tx_line_pos_oe), exp_oe(i[0], oe));
            chk(32'(tx_line_neg_oe), exp_oe(i[0], oe));
            chk(32'(rx_term_en), exp_term(i[0], t));
            chk(32'(rx_monitor_en), 32'h0000_ffff);
            apb(1'b0, TX_OE_OFS, ZERO_WORD);
            chk(rd, {16'h0000, oe});
        end
        for (i = 0; i < 8; i++) begin
            pins(1'b1, i[0] ^ i[2], i[1]);
            if (!i[1])
                xf = i[0] ^ i[2];
            else
                xm = i[0] ^ i[2];
            chk(32'(sdo_launch_fall), 32'(xf));
            chk(32'(bus_mux_mode), 32'(xm));
            apb(1'b0, STATUS_OFS, ZERO_WORD);
            chk(rd, {27'h0000_000, xm, xf, p, e, g});
            chk(32'(er), ZERO_WORD);
        end
        // Second reset in mid-run, held for the minimum low time
        apb(1'b1, TX_OE_OFS, 32'h0000_ffff);
        pins(1'b1, 1'b0, 1'b1);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (RESET_MIN_CYC) @(posedge clk);
        resetn <= 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk);
        chk(32'(tx_line_pos_oe), ZERO_WORD);
        chk(32'(sdo_launch_fall), ZERO_WORD);
        apb(1'b0, TX_OE_OFS, ZERO_WORD);
        chk(rd, 32'(TX_OE_RST));
        apb(1'b0, TEST_OFS, ZERO_WORD);
        chk(rd, 32'(TERM_CTRL_RST));
        finish_test();
    end

    initial begin
        #(CLK_PERIOD_NS * 20000);
        n_fail++;
        finish_test();
    end
endmodule
